// ---- core/udc_counter.sv ----
/*
 * udc_counter: 16-bit up/down interval counter with six output modes,
 * binary or bcd counting, gate and direction pins, register port.
 * assumes one 100 MHz clock, synchronous reset, pins asynchronous.
 */
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
module udc_counter
    import udc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [WIDTH-1:0]  reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [WIDTH-1:0]  reg_rdata,
    input  wire logic              gate_pin,
    input  wire logic              source_pin,
    input  wire logic              count_direction_pin,
    output logic                   count_out
);
    import udc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [4:0]       config_ff;
    logic [WIDTH-1:0] load_ff;
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] read_ff;
    logic [WIDTH-1:0] div_ff;
    logic [WIDTH-1:0] div_cnt_ff;
    logic [WIDTH-1:0] rdata_ff;
    udc_mode_t        mode_ff;
    logic             started_ff;
    logic             armed_ff;
    logic             running_ff;
    logic             out_ff;
    logic             half_ff;
    logic             pend_low_ff;
    logic             tick_ff;

    logic             nxt_out;
    logic [WIDTH-1:0] nxt_count;
    logic             nxt_running;
    logic             nxt_half;
    logic             nxt_pend_low;
    logic             nxt_armed;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic gate_lvl;
    logic gate_rise;
    logic src_rise;
    logic dir_lvl;

    udc_sync u_gate (
        .clock (clock),
        .reset (reset),
        .pin   (gate_pin),
        .level (gate_lvl),
        .rise  (gate_rise),
        .fall  ()
    );
    udc_sync u_src (
        .clock (clock),
        .reset (reset),
        .pin   (source_pin),
        .level (),
        .rise  (src_rise),
        .fall  ()
    );
    udc_sync u_dir (
        .clock (clock),
        .reset (reset),
        .pin   (count_direction_pin),
        .level (dir_lvl),
        .rise  (),
        .fall  ()
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_config  = reg_write && (reg_addr == UDC_ADDR_CONFIG);
    wire wr_command = reg_write && (reg_addr == UDC_ADDR_COMMAND);
    wire wr_count   = reg_write && (reg_addr == UDC_ADDR_COUNT);
    wire wr_divider = reg_write && (reg_addr == UDC_ADDR_DIVIDER);
    wire [2:0] cmd_code  = reg_wdata[UDC_CMD_CODE_LSB +: 3];
    wire       cmd_level = reg_wdata[UDC_CMD_LEVEL_BIT];
    wire       cmd_start = wr_command && reg_wdata[UDC_CMD_START_BIT];
    wire       cmd_stop  = wr_command && reg_wdata[UDC_CMD_STOP_BIT];
    wire       cmd_setup = wr_command && (cmd_code < UDC_CODE_READ);
    wire       cmd_read  = wr_command && (cmd_code == UDC_CODE_READ);
    wire       cmd_reset = wr_command && (cmd_code == UDC_CODE_RESET);

    wire gate_mode   = config_ff[UDC_CFG_GATE_BIT];
    wire dir_src     = config_ff[UDC_CFG_DIRSRC_BIT];
    wire dir_sw      = config_ff[UDC_CFG_DIR_BIT];
    wire use_tbase   = config_ff[UDC_CFG_TBASE_BIT];
    wire bcd_sel     = config_ff[UDC_CFG_BCD_BIT];

    wire count_up    = dir_src ? dir_lvl : dir_sw;

    // ------------------------------------------------------------
    // count clock: internal timebase divider or source pin edge
    // ------------------------------------------------------------
    wire div_wrap = (div_cnt_ff == UDC_ZERO16);
    wire cnt_tick = use_tbase ? tick_ff : src_rise;

    // ------------------------------------------------------------
    // enables per mode
    // ------------------------------------------------------------
    wire gate_ok   = gate_mode ? gate_lvl : 1'b1;
    wire strobe_md = (mode_ff == UDC_MODE_SW_STROBE) || (mode_ff == UDC_MODE_HW_STROBE);
    wire gated_md  = (mode_ff == UDC_MODE_TC_TOGGLE) || (mode_ff == UDC_MODE_SW_STROBE);
    // mode 0 and 4 hold the count while gate is low, whatever the gate select
    wire mode_gate = gated_md ? gate_lvl : 1'b1;
    wire trig_md   = (mode_ff == UDC_MODE_ONE_SHOT) || (mode_ff == UDC_MODE_HW_STROBE);
    wire enable    = started_ff && gate_ok && mode_gate && running_ff;
    wire step      = enable && cnt_tick;

    logic [WIDTH-1:0] stepped;
    udc_step u_step (
        .value                (count_ff),
        .count_up             (count_up),
        .decimal_count_select (bcd_sel),
        .result               (stepped)
    );

    // a load of zero runs the full range, as with a wrapping down-counter
    wire at_one   = (count_ff == UDC_ONE16);
    wire at_zero  = (count_ff == UDC_ZERO16);
    wire at_tc    = count_up ? (stepped == load_ff) : at_one;
    wire [WIDTH-1:0] half_load = {1'b0, load_ff[WIDTH-1:1]};
    wire half_tc  = count_up ? (stepped == half_load) : (count_ff == half_load + UDC_ONE16);

    // ------------------------------------------------------------
    // mode engine
    // ------------------------------------------------------------
    always_comb begin
        nxt_out      = out_ff;
        nxt_count    = count_ff;
        nxt_running  = running_ff;
        nxt_half     = half_ff;
        nxt_pend_low = 1'b0;
        nxt_armed    = armed_ff;
        if (cmd_setup) begin
            nxt_count   = count_up ? UDC_ZERO16 : load_ff;
            nxt_half    = 1'b0;
            nxt_armed   = 1'b0;
            nxt_running = (cmd_code != UDC_CODE_ONE_SHOT) && (cmd_code != UDC_CODE_HW_STROBE);
            case (cmd_code)
                UDC_CODE_TC_TOGGLE: nxt_out = 1'b0;
                default:            nxt_out = 1'b1;
            endcase
        end else if (cmd_reset) begin
            nxt_out = cmd_level;
        end else begin
            // one-shot arms on gate rise, then output falls on the next count clock
            if (trig_md && started_ff && gate_rise) begin
                nxt_armed = 1'b1;
                nxt_count = count_up ? UDC_ZERO16 : load_ff;
            end
            if (armed_ff && cnt_tick) begin
                nxt_armed   = 1'b0;
                nxt_running = 1'b1;
                if (mode_ff == UDC_MODE_ONE_SHOT) begin
                    nxt_out = 1'b0;
                end
            end
            if (pend_low_ff) begin
                nxt_out = 1'b1;
            end
            if (step) begin
                nxt_count = stepped;
                case (mode_ff)
                    UDC_MODE_TC_TOGGLE: begin
                        if (at_tc) nxt_out = 1'b1;
                    end
                    UDC_MODE_ONE_SHOT: begin
                        if (at_tc) begin
                            nxt_out     = 1'b1;
                            nxt_running = 1'b0;
                        end
                    end
                    UDC_MODE_RATE: begin
                        if (at_tc) begin
                            nxt_out      = 1'b0;
                            nxt_pend_low = 1'b1;
                            nxt_count    = count_up ? UDC_ZERO16 : load_ff;
                        end
                    end
                    UDC_MODE_SQUARE: begin
                        if (at_tc) begin
                            nxt_out   = 1'b1;
                            nxt_half  = 1'b0;
                            nxt_count = count_up ? UDC_ZERO16 : load_ff;
                        end else if (!half_ff && half_tc) begin
                            nxt_out  = 1'b0;
                            nxt_half = 1'b1;
                        end
                    end
                    UDC_MODE_SW_STROBE,
                    UDC_MODE_HW_STROBE: begin
                        if (at_tc) begin
                            nxt_out      = 1'b0;
                            nxt_pend_low = 1'b1;
                            nxt_running  = 1'b0;
                        end
                    end
                    default: nxt_out = out_ff;
                endcase
            end
        end
    end

    // pending low lasts until the next count clock for the rate and strobe modes
    wire hold_low = pend_low_ff && !cnt_tick && !cmd_setup && !cmd_reset;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            config_ff  <= UDC_CFG_RESET;
            load_ff    <= UDC_ZERO16;
            div_ff     <= UDC_DIV_RESET;
            mode_ff    <= UDC_MODE_TC_TOGGLE;
            started_ff <= 1'b0;
        end else begin
            if (wr_config)  config_ff <= reg_wdata[4:0];
            if (wr_count)   load_ff   <= reg_wdata;
            if (wr_divider) div_ff    <= reg_wdata;
            if (cmd_setup)  mode_ff   <= udc_mode_t'(cmd_code);
            if (cmd_start)  started_ff <= 1'b1;
            else if (cmd_stop) started_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            div_cnt_ff <= UDC_ZERO16;
            tick_ff    <= 1'b0;
        end else begin
            div_cnt_ff <= div_wrap ? div_ff : div_cnt_ff - UDC_ONE16;
            tick_ff    <= div_wrap;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count_ff    <= UDC_ZERO16;
            out_ff      <= 1'b0;
            running_ff  <= 1'b1;
            half_ff     <= 1'b0;
            armed_ff    <= 1'b0;
            pend_low_ff <= 1'b0;
        end else begin
            count_ff    <= nxt_count;
            out_ff      <= hold_low ? 1'b0 : nxt_out;
            running_ff  <= nxt_running;
            half_ff     <= nxt_half;
            armed_ff    <= nxt_armed;
            pend_low_ff <= hold_low ? 1'b1 : nxt_pend_low;
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    wire [WIDTH-1:0] status_word = {{(WIDTH-5){1'b0}}, half_ff, armed_ff,
                                    running_ff, started_ff, out_ff};
    logic [WIDTH-1:0] rd_mux;
    always_comb begin
        case (reg_addr)
            UDC_ADDR_CONFIG:  rd_mux = {{(WIDTH-5){1'b0}}, config_ff};
            UDC_ADDR_COUNT:   rd_mux = load_ff;
            UDC_ADDR_READ:    rd_mux = read_ff;
            UDC_ADDR_STATUS:  rd_mux = status_word;
            UDC_ADDR_DIVIDER: rd_mux = div_ff;
            default:          rd_mux = UDC_ZERO16;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            read_ff  <= UDC_ZERO16;
            rdata_ff <= UDC_ZERO16;
        end else begin
            if (cmd_read) read_ff <= count_ff;
            rdata_ff <= reg_read ? rd_mux : UDC_ZERO16;
        end
    end

    assign reg_rdata = rdata_ff;
    assign count_out = out_ff;
endmodule

// ---- core/udc_pkg.sv ----
/*
 * udc_pkg: shared constants for the up/down interval counter.
 * assumes a single 100 MHz clock domain and a plain register port.
 */
package udc_pkg;
    // ------------------------------------------------------------
    // register map (word index = byte offset)
    // ------------------------------------------------------------
    localparam logic [3:0] UDC_ADDR_CONFIG  = 4'h0;
    localparam logic [3:0] UDC_ADDR_COMMAND = 4'h1;
    localparam logic [3:0] UDC_ADDR_COUNT   = 4'h2;
    localparam logic [3:0] UDC_ADDR_READ    = 4'h3;
    localparam logic [3:0] UDC_ADDR_STATUS  = 4'h4;
    localparam logic [3:0] UDC_ADDR_DIVIDER = 4'h5;

    // config field positions
    localparam int UDC_CFG_GATE_BIT   = 0;
    localparam int UDC_CFG_DIRSRC_BIT = 1;
    localparam int UDC_CFG_DIR_BIT    = 2;
    localparam int UDC_CFG_TBASE_BIT  = 3;
    localparam int UDC_CFG_BCD_BIT    = 4;
    localparam logic [4:0] UDC_CFG_RESET = 5'h00;

    // command field positions
    localparam int UDC_CMD_CODE_LSB   = 0;
    localparam int UDC_CMD_LEVEL_BIT  = 3;
    localparam int UDC_CMD_START_BIT  = 4;
    localparam int UDC_CMD_STOP_BIT   = 5;

    // control codes
    localparam logic [2:0] UDC_CODE_TC_TOGGLE = 3'h0;
    localparam logic [2:0] UDC_CODE_ONE_SHOT  = 3'h1;
    localparam logic [2:0] UDC_CODE_RATE      = 3'h2;
    localparam logic [2:0] UDC_CODE_SQUARE    = 3'h3;
    localparam logic [2:0] UDC_CODE_SW_STROBE = 3'h4;
    localparam logic [2:0] UDC_CODE_HW_STROBE = 3'h5;
    localparam logic [2:0] UDC_CODE_READ      = 3'h6;
    localparam logic [2:0] UDC_CODE_RESET     = 3'h7;

    localparam logic [15:0] UDC_ZERO16       = 16'h0000;
    localparam logic [15:0] UDC_ONE16        = 16'h0001;
    localparam logic [15:0] UDC_DIV_RESET    = 16'h0063;
    localparam logic [3:0]  UDC_DIGIT_NINE   = 4'h9;
    localparam logic [3:0]  UDC_DIGIT_ZERO   = 4'h0;
    localparam logic [3:0]  UDC_DIGIT_ONE    = 4'h1;

    typedef enum logic [2:0] {
        UDC_MODE_TC_TOGGLE,
        UDC_MODE_ONE_SHOT,
        UDC_MODE_RATE,
        UDC_MODE_SQUARE,
        UDC_MODE_SW_STROBE,
        UDC_MODE_HW_STROBE
    } udc_mode_t;
endpackage

// ---- core/udc_step.sv ----
/*
 * udc_step: one up or down step of a binary or four-decade bcd count.
 * assumes bcd input digits are legal when bcd is selected.
 */
`timescale 1ns/10ps
module udc_step
    import udc_pkg::*;
(
    input  wire logic [15:0] value,
    input  wire logic        count_up,
    input  wire logic        decimal_count_select,
    output logic      [15:0] result
);
    logic [15:0] bin_res;
    logic [15:0] bcd_res;
    logic [4:0]  carry;

    assign bin_res  = count_up ? value + UDC_ONE16 : value - UDC_ONE16;
    assign carry[0] = 1'b1;

    // ------------------------------------------------------------
    // per-decade roll between nine and zero
    // ------------------------------------------------------------
    genvar d;
    generate
        for (d = 0; d < 4; d++) begin : g_digit
            wire [3:0] dig;
            wire       at_edge;
            assign dig     = value[4*d +: 4];
            assign at_edge = count_up ? (dig == UDC_DIGIT_NINE) : (dig == UDC_DIGIT_ZERO);
            assign bcd_res[4*d +: 4] = !carry[d] ? dig :
                                       at_edge ? (count_up ? UDC_DIGIT_ZERO : UDC_DIGIT_NINE) :
                                       (count_up ? dig + UDC_DIGIT_ONE
                                                 : dig - UDC_DIGIT_ONE);
            assign carry[d+1] = carry[d] & at_edge;
        end
    endgenerate

    assign result = decimal_count_select ? bcd_res : bin_res;
endmodule

// ---- core/udc_sync.sv ----
/*
 * udc_sync: two-flop synchroniser with rise and fall detect on the
 * synchronised level. assumes input is asynchronous to clock.
 */
`timescale 1ns/10ps
module udc_sync (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // edges look only at the second flop onward
    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;
endmodule

// ---- bench/udc_counter_chk.sv ----
/*
 * udc_counter_chk: port-level assertions for udc_counter.
 * assumes one clock, synchronous active-high reset, bound by name below.
 */
`timescale 1ns/10ps
module udc_counter_chk
    import udc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic             clock,
    input wire logic             reset,
    input wire logic [3:0]       reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [WIDTH-1:0] reg_rdata,
    input wire logic             gate_pin,
    input wire logic             source_pin,
    input wire logic             count_direction_pin,
    input wire logic             count_out
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [2:0] mode_ff;
    logic       strobed_ff;
    logic       out_q_ff;
    logic       wr_q_ff;
    wire        cmd_wr    = reg_write && (reg_addr == UDC_ADDR_COMMAND);
    wire  [2:0] cmd_code  = reg_wdata[2:0];
    wire        is_strobe = (mode_ff == UDC_CODE_SW_STROBE) || (mode_ff == UDC_CODE_HW_STROBE);

    // a fall not caused by a write marks the strobe as spent
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_ff    <= UDC_CODE_TC_TOGGLE;
            strobed_ff <= 1'b0;
            out_q_ff   <= 1'b0;
            wr_q_ff    <= 1'b0;
        end else begin
            out_q_ff <= count_out;
            wr_q_ff  <= reg_write;
            if (cmd_wr && cmd_code < UDC_CODE_READ) begin
                mode_ff <= cmd_code;
            end
            if (reg_write) begin
                strobed_ff <= 1'b0;
            end else if (is_strobe && out_q_ff && !count_out && !wr_q_ff) begin
                strobed_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_rdata_idle; !reg_read |=> reg_rdata == '0; endproperty
    property p_unmapped; reg_read && reg_addr > UDC_ADDR_DIVIDER |=> reg_rdata == '0; endproperty
    property p_mode0_low; cmd_wr && cmd_code == UDC_CODE_TC_TOGGLE |=> !count_out; endproperty
    property p_mode0_hold;
        mode_ff == UDC_CODE_TC_TOGGLE && count_out && !reg_write |=> count_out;
    endproperty
    property p_force;
        cmd_wr && cmd_code == UDC_CODE_RESET |=> count_out == $past(reg_wdata[UDC_CMD_LEVEL_BIT]);
    endproperty
    property p_sw_high; cmd_wr && cmd_code == UDC_CODE_SW_STROBE |=> count_out; endproperty
    property p_hw_high; cmd_wr && cmd_code == UDC_CODE_HW_STROBE |=> count_out [*2]; endproperty
    property p_strobe_stop; strobed_ff && count_out && !reg_write |=> count_out; endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_mode0_low: assert property (p_mode0_low) else $error("mode 0 program not low");
    a_mode0_hold: assert property (p_mode0_hold) else $error("mode 0 output fell");
    a_force: assert property (p_force) else $error("forced level wrong");
    a_sw_high: assert property (p_sw_high) else $error("mode 4 not high");
    a_hw_high: assert property (p_hw_high) else $error("mode 5 not high");
    a_strobe_stop: assert property (p_strobe_stop) else $error("strobe repeated");

    c_mode0_tc: cover property (mode_ff == UDC_CODE_TC_TOGGLE && $rose(count_out));
    c_rate: cover property (mode_ff == UDC_CODE_RATE && $fell(count_out));
    c_square: cover property (mode_ff == UDC_CODE_SQUARE && $fell(count_out));
    c_strobe: cover property ($rose(strobed_ff));
endmodule

bind udc_counter udc_counter_chk #(.WIDTH(WIDTH)) chk_u (
    .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .gate_pin, .source_pin, .count_direction_pin, .count_out);

// ---- bench/udc_pin_model.sv ----
/*
 * udc_pin_model: external gate, source and direction drivers.
 * assumes its tasks are called from the bench; pins move after posedge.
 */
`timescale 1ns/10ps
module udc_pin_model (
    input  wire logic clock,
    output logic      gate_pin,
    output logic      source_pin,
    output logic      count_direction_pin
);
    // source stands low between bursts, as a stopped clock would
    initial begin
        gate_pin = 1'b0;
        source_pin = 1'b0;
        count_direction_pin = 1'b0;
    end

    task automatic set_gate(input logic v);
        @(posedge clock);
        gate_pin <= v;
    endtask

    task automatic set_dir(input logic v);
        @(posedge clock);
        count_direction_pin <= v;
    endtask

    // half period in clocks; 1 is the shortest the synchroniser sees
    task automatic pulses(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge clock);
            source_pin <= 1'b1;
            repeat (h) @(posedge clock);
            source_pin <= 1'b0;
        end
    endtask
endmodule

// ---- bench/tb_top.sv ----
/*
 * tb_top: self-checking bench for udc_counter.
 * assumes udc_pin_model on the pins and the bound checker.
 */
`timescale 1ns/10ps
module tb_top;
    import udc_pkg::*;
    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic        gate_pin;
    logic        source_pin;
    logic        count_direction_pin;
    logic        count_out;
    int          n_fail = 0;
    int          checks = 0;

    always #5 clock = ~clock;

    udc_counter #(.WIDTH(16)) dut_u (
        .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .gate_pin, .source_pin, .count_direction_pin, .count_out);
    udc_pin_model pins_u (.clock, .gate_pin, .source_pin, .count_direction_pin);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(what, reg_rdata, exp);
    endtask

    // decades roll 9 to 0 with carry, 0 to 9 with borrow
    function automatic logic [15:0] fstep(input logic [15:0] v, input logic up, input logic bcd);
        logic c;
        c = 1'b1;
        if (!bcd) return up ? v + 16'h0001 : v - 16'h0001;
        for (int i = 0; i < 4; i++) begin
            if (c && up) begin
                if (v[i*4+:4] == 4'h9) v[i*4+:4] = 4'h0;
                else begin v[i*4+:4] += 4'h1; c = 1'b0; end
            end else if (c) begin
                if (v[i*4+:4] == 4'h0) v[i*4+:4] = 4'h9;
                else begin v[i*4+:4] -= 4'h1; c = 1'b0; end
            end
        end
        return v;
    endfunction

    task automatic span(input logic v, output int n);
        n = 0;
        while (count_out === v && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask

    // skip to the first full low phase, then time low and following high
    task automatic measure(output int lo, output int hi);
        int skip;
        @(negedge clock);
        span(1'b0, skip);
        span(1'b1, skip);
        span(1'b0, lo);
        span(1'b1, hi);
    endtask

    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        $display("Error watchdog expected done seen hang");
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    logic [4:0] t_cfg [10] = '{5'h00, 5'h00, 5'h01, 5'h01, 5'h04, 5'h02, 5'h06, 5'h10,
                               5'h14, 5'h00};
    logic [9:0] t_start = 10'h3FD;
    logic [9:0] t_gate = 10'h1FA;
    logic [9:0] t_pin = 10'h020;

    initial begin
        int lo, hi, n, k, d;
        logic [15:0] load, exp, r;
        logic [4:0] cfg;
        logic [2:0] m;
        logic up, en;
        void'($urandom(32'h6CEE));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        rchk("config", UDC_ADDR_CONFIG, 16'h0000);
        rchk("divider", UDC_ADDR_DIVIDER, UDC_DIV_RESET);
        rchk("status", UDC_ADDR_STATUS, 16'h0004);
        wr(4'hA, 16'hFFFF);
        rchk("unmapped", 4'hA, 16'h0000);
        r = 16'($urandom_range(65535));
        wr(UDC_ADDR_COUNT, r);
        rchk("load", UDC_ADDR_COUNT, r);
        // counting table: gate, start, direction, bcd
        for (int i = 0; i < 10; i++) begin
            cfg = t_cfg[i];
            load = cfg[4] ? (cfg[2] ? 16'h0050 : 16'h1000) : 16'(20 + $urandom_range(180));
            k = cfg[4] ? (cfg[2] ? 12 : 3) : 3 + $urandom_range(5);
            m = (i == 9) ? UDC_CODE_TC_TOGGLE : UDC_CODE_RATE;
            up = cfg[1] ? t_pin[i] : cfg[2];
            en = t_start[i] && (t_gate[i] || !cfg[0]) && (t_gate[i] || m != 3'h0);
            pins_u.set_gate(t_gate[i]);
            pins_u.set_dir(t_pin[i]);
            wr(UDC_ADDR_COMMAND, 16'h0020);
            wr(UDC_ADDR_CONFIG, {11'h000, cfg});
            wr(UDC_ADDR_COUNT, load);
            wr(UDC_ADDR_COMMAND, {11'h000, t_start[i], 1'b0, m});
            pins_u.pulses(k, 2 + $urandom_range(3));
            repeat (8) @(posedge clock);
            exp = up ? 16'h0000 : load;
            if (en) repeat (k) exp = fstep(exp, up, cfg[4]);
            wr(UDC_ADDR_COMMAND, {13'h0000, UDC_CODE_READ});
            rchk("count", UDC_ADDR_READ, exp);
        end
        // mode 0 toward terminal count, then forced levels
        n = 2 + $urandom_range(4);
        pins_u.set_gate(1'b1);
        wr(UDC_ADDR_CONFIG, 16'h0000);
        wr(UDC_ADDR_COUNT, 16'(n));
        wr(UDC_ADDR_COMMAND, 16'h0010);
        @(negedge clock);
        chk("out", 16'(count_out), 16'h0000);
        pins_u.pulses(n - 1, 3);
        repeat (8) @(posedge clock);
        chk("out", 16'(count_out), 16'h0000);
        pins_u.pulses(1, 3);
        repeat (8) @(posedge clock);
        chk("out", 16'(count_out), 16'h0001);
        pins_u.pulses(2, 3);
        repeat (8) @(posedge clock);
        chk("out", 16'(count_out), 16'h0001);
        wr(UDC_ADDR_COMMAND, 16'h0007);
        @(negedge clock);
        chk("forced", 16'(count_out), 16'h0000);
        wr(UDC_ADDR_COMMAND, 16'h000F);
        @(negedge clock);
        chk("forced", 16'(count_out), 16'h0001);
        // waveforms on the internal timebase; mode 1 and 5 wait for gate
        for (int j = 1; j < 6; j++) begin
            m = 3'(j);
            d = $urandom_range(2);
            load = 16'(2 * (2 + $urandom_range(8)));
            pins_u.set_gate(j != 1 && j != 5);
            wr(UDC_ADDR_COMMAND, 16'h0020);
            wr(UDC_ADDR_DIVIDER, 16'(d));
            wr(UDC_ADDR_CONFIG, 16'h0008);
            wr(UDC_ADDR_COUNT, load);
            wr(UDC_ADDR_COMMAND, {12'h001, 1'b0, m});
            if (j == 1 || j == 5) begin
                @(negedge clock);
                span(1'b1, n);
                chk("untriggered", 16'(n), 16'd3000);
                pins_u.set_gate(1'b1);
            end
            measure(lo, hi);
            exp = (j == 1) ? 16'(load * (d + 1)) : (j == 3) ? 16'(load / 2 * (d + 1)) : 16'(d + 1);
            chk("low", 16'(lo), exp);
            exp = (j == 2 || j == 3) ? 16'(load * (d + 1)) - exp : 16'd3000;
            chk("high", 16'(hi), exp);
        end
        conclude();
    end
endmodule
